// file: rtl/interbus_controller.sv
// controller end of the module interbus: transfers, interrupts, line tick
//
// Overview of operation
// (RQ1) modules reached by plain memory cycles
// (RQ2) indirect access needs earlier direct access
// (RQ3) transfer ends on module acknowledge
// (RQ4) controller drives write data or captures read
// (RQ5) addressed module asserts acknowledge
// (RQ6) internal interrupts at priorities one and six
// (RQ7) missing acknowledge raises its interrupt
// (RQ8) fixed timeout ends cycle without acknowledge
// (RQ9) tick at eight times line frequency
// (RQ10) sampling and display paced by tick
// (RQ11) module requests by pulling shared line low
// (RQ12) grant issued when processor accepts interrupt
// (RQ13) module acks with vector bit on 1-3
// (RQ14) highest priority vector placed on data bus
// (RQ15) reset from line reference lane monitoring
// (RQ16) status word latched each instruction start
// (RQ17) wait state entered and left per access
// (RQ18) unguarded bus carries full handshake trio
// (RQ19) guarded bus carries acknowledge only
// (RQ20) both buses share address, handshake, data
// (RQ21) only fifth real-time lane used unguarded
// (RQ22) eight data lines, sixteen address lines
// (RQ23) top address bit selects, inverted bits out
`timescale 1ns/1ps
`default_nettype none
module interbus_controller
(
    input wire logic clk, // system clock
    input wire logic reset, // sync reset, high
    interbus_if.controller bus, // unguarded interbus
    input wire logic cpu_req, // pulse: memory cycle start
    input wire logic cpu_wr, // 1 write, 0 read
    input wire logic [interbus_pkg::ADDR_W-1:0] cpu_address_lines, // address
    input wire logic [interbus_pkg::DATA_W-1:0] cpu_data_out, // write data
    input wire logic cpu_sync, // pulse: instruction cycle start
    input wire logic [interbus_pkg::DATA_W-1:0] cpu_status, // status word
    input wire logic cpu_int_enable, // cpu ready for interrupt
    input wire logic line_pulse, // pulse: shaped line edge
    output logic [interbus_pkg::DATA_W-1:0] cpu_data_lines, // data or vector
    output logic cpu_ready, // low holds cpu in wait
    output logic cpu_int, // interrupt pending to cpu
    output logic cpu_reset, // hardware reset to cpu
    output logic [interbus_pkg::DATA_W-1:0] status_latched, // latched status
    output logic missing_ack_irq, // pulse: no acknowledge
    output logic line_tick_irq, // pulse: line tick
    output logic sample_strobe, // pulse: converter sample pace
    output logic digit_strobe // pulse: display digit pace
);
    import interbus_pkg::*;
    localparam int TO_W = $clog2(ACK_TIMEOUT_CYC + 1);
    localparam int LP_W = $clog2(LINE_LOSS_CYC + 1);
    localparam logic [TO_W-1:0] TO_LAST = TO_W'(ACK_TIMEOUT_CYC - 1);
    localparam logic [LP_W-1:0] LOSS_LAST = LP_W'(LINE_LOSS_CYC - 1);

    ctrl_state_t st_reg, st_next;
    logic [TO_W-1:0] to_reg, to_next;
    logic [IC_W-1:0] ic_reg, ic_next;
    logic sel_n_reg, sel_n_next, wr_n_reg, wr_n_next;
    logic [DATA_W-1:0] do_reg, do_next, db_reg, db_next;
    logic oe_n_reg, oe_n_next, rdy_reg, rdy_next;
    logic grant_reg, grant_next, int_reg, int_next;
    logic mack_reg, mack_next, ack_pend_reg, ack_pend_next;
    logic tick_pend_reg, tick_pend_next, tick_reg, tick_next;
    logic [DATA_W-1:0] stat_reg, stat_next;
    // tick generator and line monitor
    logic [LP_W-1:0] per_reg, per_next, meas_reg, meas_next;
    logic [LP_W-1:0] tcnt_reg, tcnt_next;
    logic [2:0] tnum_reg, tnum_next;
    logic rst_reg, rst_next, samp_reg, samp_next, dig_reg, dig_next;

    // tick: measured line period divided by eight, relocked each edge
    always_comb
    begin
        meas_next = meas_reg + 1'b1;
        per_next = per_reg;
        tcnt_next = tcnt_reg + 1'b1;
        tnum_next = tnum_reg;
        tick_next = 1'b0;
        rst_next = rst_reg;
        samp_next = 1'b0;
        dig_next = 1'b0;
        if (line_pulse)
        begin
            per_next = meas_reg >> $clog2(TICKS_PER_LINE); // RQ9
            meas_next = '0;
            tcnt_next = '0;
            tnum_next = '0;
            tick_next = !rst_reg; // RQ9
            rst_next = 1'b0; // RQ15
        end
        else if (meas_reg == LOSS_LAST)
        begin
            rst_next = 1'b1; // RQ15
            meas_next = meas_reg;
        end
        else if (tcnt_reg == per_reg && per_reg != '0
                 && tnum_reg != 3'(TICKS_PER_LINE - 1))
        begin
            tcnt_next = '0;
            tnum_next = tnum_reg + 1'b1;
            tick_next = !rst_reg; // RQ9
        end
        if (tick_reg)
        begin
            dig_next = 1'b1; // RQ10
            samp_next = tnum_reg[0]; // RQ10
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            meas_reg <= '0;
            per_reg <= '0;
            tcnt_reg <= '0;
            tnum_reg <= '0;
            tick_reg <= 1'b0;
            rst_reg <= 1'b1;
            samp_reg <= 1'b0;
            dig_reg <= 1'b0;
        end
        else
        begin
            meas_reg <= meas_next;
            per_reg <= per_next;
            tcnt_reg <= tcnt_next;
            tnum_reg <= tnum_next;
            tick_reg <= tick_next;
            rst_reg <= rst_next;
            samp_reg <= samp_next;
            dig_reg <= dig_next;
        end
    end

    // transfer and interrupt sequencer
    always_comb
    begin
        st_next = st_reg;
        to_next = to_reg;
        ic_next = ic_reg;
        sel_n_next = 1'b1;
        wr_n_next = 1'b1;
        do_next = do_reg;
        db_next = db_reg;
        oe_n_next = 1'b1;
        rdy_next = rdy_reg;
        grant_next = 1'b0;
        mack_next = 1'b0;
        // sets beat clears taken in the same cycle
        ack_pend_next = ack_pend_reg;
        tick_pend_next = tick_pend_reg | tick_reg; // RQ6
        stat_next = stat_reg;
        if (cpu_sync)
            stat_next = cpu_status; // RQ16
        case (st_reg)
            ST_IDLE:
            begin
                rdy_next = 1'b1;
                if (cpu_req && cpu_address_lines[SEL_BIT]) // RQ1 RQ23
                begin
                    ic_next = ~cpu_address_lines[IC_HI:IC_LO]; // RQ23
                    sel_n_next = 1'b0;
                    wr_n_next = !cpu_wr;
                    do_next = cpu_data_out; // RQ4
                    oe_n_next = !cpu_wr; // RQ4
                    rdy_next = 1'b0; // RQ17
                    to_next = '0;
                    st_next = ST_XFER;
                end
                else if (cpu_int_enable && !int_reg && !ack_pend_reg
                         && !tick_pend_reg && !bus.module_irq_request_n)
                begin
                    grant_next = 1'b1; // RQ12
                    to_next = '0;
                    st_next = ST_GRANT;
                end
            end
            ST_XFER:
            begin
                sel_n_next = 1'b0;
                wr_n_next = wr_n_reg;
                oe_n_next = oe_n_reg;
                to_next = to_reg + 1'b1;
                if (!bus.ack_n) // RQ3
                begin
                    if (wr_n_reg)
                        db_next = bus.module_data_lines; // RQ4
                    st_next = ST_DONE;
                end
                else if (to_reg == TO_LAST) // RQ8
                begin
                    mack_next = 1'b1; // RQ7
                    ack_pend_next = 1'b1; // RQ7
                    db_next = '1;
                    st_next = ST_DONE;
                end
            end
            ST_GRANT:
            begin
                grant_next = 1'b1;
                to_next = to_reg + 1'b1;
                if (!bus.ack_n)
                begin
                    db_next = bus.module_data_lines &
                        8'(8'hFF << VEC_LO) &
                        8'(8'hFF >> (DATA_W - 1 - VEC_HI));
                    st_next = ST_STATUS;
                end
                else if (to_reg == TO_LAST)
                begin
                    mack_next = 1'b1; // RQ7
                    ack_pend_next = 1'b1;
                    st_next = ST_IDLE;
                end
            end
            ST_DONE:
            begin
                rdy_next = 1'b1; // RQ17
                if (bus.ack_n)
                    st_next = ST_IDLE;
            end
            ST_STATUS:
            begin
                if (bus.ack_n)
                    st_next = ST_IDLE;
            end
            default:
                st_next = ST_IDLE;
        endcase
        // vector the highest pending source at the cycle boundary
        int_next = 1'b0;
        if (cpu_int_enable && st_reg == ST_IDLE && !int_reg)
        begin
            if (ack_pend_reg) // RQ14
            begin
                db_next = PRIO_ACK;
                ack_pend_next = 1'b0;
                int_next = 1'b1;
            end
            else if (tick_pend_reg) // RQ14
            begin
                db_next = PRIO_TICK;
                tick_pend_next = tick_reg;
                int_next = 1'b1;
            end
        end
        if (st_reg == ST_STATUS && bus.ack_n)
            int_next = 1'b1; // RQ14
        if (mack_next)
            ack_pend_next = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st_reg <= ST_IDLE;
            to_reg <= '0;
            ic_reg <= '1;
            sel_n_reg <= 1'b1;
            wr_n_reg <= 1'b1;
            do_reg <= '0;
            db_reg <= '0;
            oe_n_reg <= 1'b1;
            rdy_reg <= 1'b1;
            grant_reg <= 1'b0;
            int_reg <= 1'b0;
            mack_reg <= 1'b0;
            ack_pend_reg <= 1'b0;
            tick_pend_reg <= 1'b0;
            stat_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
            to_reg <= to_next;
            ic_reg <= ic_next;
            sel_n_reg <= sel_n_next;
            wr_n_reg <= wr_n_next;
            do_reg <= do_next;
            db_reg <= db_next;
            oe_n_reg <= oe_n_next;
            rdy_reg <= rdy_next;
            grant_reg <= grant_next;
            int_reg <= int_next;
            mack_reg <= mack_next;
            ack_pend_reg <= ack_pend_next;
            tick_pend_reg <= tick_pend_next;
            stat_reg <= stat_next;
        end
    end

    assign bus.module_addr_ctrl = ic_reg; // RQ23
    assign bus.sel_n = sel_n_reg;
    assign bus.wr_n = wr_n_reg;
    assign bus.ctl_data_o = do_reg;
    assign bus.ctl_data_oe_n = oe_n_reg;
    assign bus.irq_grant = grant_reg; // RQ12
    assign bus.realtime_lanes = RT_W'(tick_reg) << RT_REF_IDX; // RQ21
    assign bus.external_trigger = 1'b0;
    assign cpu_data_lines = db_reg; // RQ22
    assign cpu_ready = rdy_reg;
    assign cpu_int = int_reg;
    assign cpu_reset = rst_reg;
    assign status_latched = stat_reg;
    assign missing_ack_irq = mack_reg;
    assign line_tick_irq = tick_reg;
    assign sample_strobe = samp_reg;
    assign digit_strobe = dig_reg;
endmodule
`default_nettype wire

// file: rtl/interbus_if.sv
// interbus wires between the controller and one plug-in module
`timescale 1ns/1ps
`default_nettype none
interface interbus_if;
    import interbus_pkg::*;
    logic [IC_W-1:0] module_addr_ctrl;
    logic sel_n;
    logic wr_n;
    logic [DATA_W-1:0] ctl_data_o;
    logic ctl_data_oe_n;
    logic [DATA_W-1:0] mod_data_o;
    logic mod_data_oe_n;
    logic [DATA_W-1:0] module_data_lines;
    logic ack_n; // RQ19 RQ20
    logic module_irq_request_n;
    logic irq_grant;
    logic [RT_W-1:0] realtime_lanes;
    logic scan_advance; // RQ18
    logic external_trigger;
    logic front_sense;
    assign module_data_lines = !ctl_data_oe_n ? ctl_data_o :
        (!mod_data_oe_n ? mod_data_o : '1);
    modport controller (output module_addr_ctrl, sel_n, wr_n, ctl_data_o,
        ctl_data_oe_n, irq_grant, realtime_lanes, external_trigger,
        input module_data_lines, ack_n, module_irq_request_n, scan_advance,
        front_sense);
    modport module_end (input module_addr_ctrl, sel_n, wr_n,
        module_data_lines, irq_grant, realtime_lanes, external_trigger,
        output mod_data_o, mod_data_oe_n, ack_n, module_irq_request_n,
        scan_advance, front_sense);
endinterface
`default_nettype wire

// file: rtl/interbus_module.sv
// plug-in module end: decodes its address, acks, requests interrupts
`timescale 1ns/1ps
`default_nettype none
module interbus_module
#(
    parameter logic [interbus_pkg::IC_W-1:0] MY_ADDR = 7'h10, // base address
    parameter logic [2:0] MY_VEC = 3'h2 // priority vector bit
)(
    input wire logic clk, // system clock
    input wire logic reset, // sync reset, high
    interbus_if.module_end bus, // interbus
    input wire logic irq_req, // pulse: ask for service
    input wire logic [interbus_pkg::DATA_W-1:0] rd_data, // read data
    output logic [interbus_pkg::DATA_W-1:0] wr_data, // last written data
    output logic wr_strobe, // pulse: write taken
    output logic indirect_hit // pulse: indirect access taken
);
    import interbus_pkg::*;
    logic armed_reg, armed_next;
    logic ack_reg, ack_next;
    logic irq_reg, irq_next;
    logic oe_reg, oe_next;
    logic [DATA_W-1:0] do_reg, do_next;
    logic [DATA_W-1:0] wd_reg, wd_next;
    logic ws_reg, ws_next;
    logic ih_reg, ih_next;
    logic direct, indirect;

    // low address bits split: top six bits base, low bit flags indirect
    assign direct = !bus.sel_n && bus.module_addr_ctrl == MY_ADDR;
    assign indirect = !bus.sel_n &&
        bus.module_addr_ctrl == (MY_ADDR | 7'h01);

    always_comb
    begin
        armed_next = armed_reg;
        ack_next = 1'b0;
        irq_next = irq_reg | irq_req;
        oe_next = 1'b1;
        do_next = do_reg;
        wd_next = wd_reg;
        ws_next = 1'b0;
        ih_next = 1'b0;
        if (bus.irq_grant && irq_reg)
        begin
            ack_next = 1'b1; // RQ13
            oe_next = 1'b0;
            do_next = '0;
            do_next[MY_VEC] = 1'b1; // RQ13
            irq_next = irq_req;
        end
        else if (direct || (indirect && armed_reg)) // RQ2
        begin
            ack_next = 1'b1; // RQ5
            if (direct)
                armed_next = 1'b1; // RQ2
            else
                ih_next = !ack_reg;
            if (bus.wr_n)
            begin
                oe_next = 1'b0;
                do_next = rd_data;
            end
            else if (!ack_reg)
            begin
                wd_next = bus.module_data_lines;
                ws_next = 1'b1;
            end
        end
        else if (indirect)
            armed_next = 1'b0; // RQ2
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            armed_reg <= 1'b0;
            ack_reg <= 1'b0;
            irq_reg <= 1'b0;
            oe_reg <= 1'b1;
            do_reg <= '0;
            wd_reg <= '0;
            ws_reg <= 1'b0;
            ih_reg <= 1'b0;
        end
        else
        begin
            armed_reg <= armed_next;
            ack_reg <= ack_next;
            irq_reg <= irq_next;
            oe_reg <= oe_next;
            do_reg <= do_next;
            wd_reg <= wd_next;
            ws_reg <= ws_next;
            ih_reg <= ih_next;
        end
    end

    assign bus.ack_n = !ack_reg; // RQ5
    assign bus.module_irq_request_n = !irq_reg; // RQ11
    assign bus.mod_data_oe_n = oe_reg;
    assign bus.mod_data_o = do_reg;
    assign bus.scan_advance = 1'b0;
    assign bus.front_sense = 1'b1;
    assign wr_data = wd_reg;
    assign wr_strobe = ws_reg;
    assign indirect_hit = ih_reg;
endmodule
`default_nettype wire

// file: rtl/interbus_pkg.sv
// constants and types shared by both ends of the module interbus
`default_nettype none
package interbus_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int IC_W = 7;
    localparam int RT_W = 8;
    localparam int SEL_BIT = 15;
    localparam int IC_LO = 8;
    localparam int IC_HI = 14;
    localparam int RT_REF_IDX = 4;
    localparam int VEC_LO = 1;
    localparam int VEC_HI = 3;
    localparam int CLK_MHZ = 200;
    localparam int ACK_TIMEOUT_NS = 2000;
    localparam int ACK_TIMEOUT_CYC = (ACK_TIMEOUT_NS * CLK_MHZ) / 1000;
    localparam int TICKS_PER_LINE = 8;
    localparam int LINE_PERIOD_NS = 20000000;
    localparam int LINE_PERIOD_CYC = (LINE_PERIOD_NS / 1000) * CLK_MHZ;
    localparam int LINE_LOSS_CYC = 2 * LINE_PERIOD_CYC;
    localparam logic [7:0] PRIO_ACK = 8'h01;
    localparam logic [7:0] PRIO_TICK = 8'h06;
    localparam logic [2:0] VEC_NONE = 3'h0;
    localparam logic [2:0] INDIRECT_BIT = 3'h6;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_XFER = 3'b001,
        ST_GRANT = 3'b010,
        ST_DONE = 3'b011,
        ST_STATUS = 3'b100
    } ctrl_state_t;
endpackage
`default_nettype wire

// file: verif/interbus_props.sv
// concurrent checks on the wires between controller and module
`timescale 1ns/1ps
`default_nettype none
module interbus_props
(
    input wire logic clk, // system clock
    input wire logic reset, // sync reset, high
    input wire logic sel_n, // transfer select
    input wire logic wr_n, // low on writes
    input wire logic ctl_data_oe_n, // controller drives data
    input wire logic mod_data_oe_n, // module drives data
    input wire logic [interbus_pkg::DATA_W-1:0] module_data_lines, // data
    input wire logic ack_n, // module acknowledge
    input wire logic module_irq_request_n, // shared request
    input wire logic irq_grant, // interrupt grant
    input wire logic [interbus_pkg::RT_W-1:0] realtime_lanes // lanes
);
    import interbus_pkg::*;
    // timeout of 400 cycles plus launch and release slack
    localparam int T_MAX = 405;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence s_sel_start;
        $fell(sel_n);
    endsequence
    sequence s_grant_start;
        $rose(irq_grant);
    endsequence
    AST_SEL_HOLD: assert property (s_sel_start |-> !sel_n [*3])
        else $error("select released early");
    AST_SEL_BOUNDED: assert property (s_sel_start |-> ##[1:T_MAX] sel_n)
        else $error("select held past timeout");
    AST_ACK_RELEASE: assert property (
        $rose(sel_n) && !irq_grant |-> ##[0:2] ack_n)
        else $error("acknowledge not released");
    AST_ACK_CAUSE: assert property (
        $fell(ack_n) |-> !sel_n || irq_grant)
        else $error("acknowledge without select");
    AST_WR_DRIVE: assert property (!sel_n && !wr_n |-> !ctl_data_oe_n)
        else $error("write data not driven");
    AST_RD_FREE: assert property (!sel_n && wr_n |-> ctl_data_oe_n)
        else $error("controller drives on read");
    AST_ONE_DRIVER: assert property (ctl_data_oe_n || mod_data_oe_n)
        else $error("data lines driven twice");
    AST_GRANT_CAUSE: assert property (
        s_grant_start |-> sel_n && !$past(module_irq_request_n))
        else $error("grant without request");
    AST_GRANT_ACK: assert property (s_grant_start |-> ##[1:3] !ack_n)
        else $error("no acknowledge after grant");
    AST_VECTOR_BIT: assert property (
        irq_grant && !ack_n |-> $onehot(module_data_lines[VEC_HI:VEC_LO]))
        else $error("vector not one bit");
    AST_RT_UNUSED: assert property ((realtime_lanes & 8'hEF) == 8'h00)
        else $error("unused lane driven");
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench: controller and module face each other
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import interbus_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cpu_req = 1'b0;
    logic cpu_wr = 1'b0;
    logic [ADDR_W-1:0] addr = 16'h0000;
    logic [DATA_W-1:0] wdat = 8'h00;
    logic cpu_sync = 1'b0;
    logic [DATA_W-1:0] cpu_status = 8'h00;
    logic line_pulse = 1'b0;
    logic irq_req = 1'b0;
    logic int_en = 1'b1;
    logic [DATA_W-1:0] rd_data = 8'h00;
    logic [DATA_W-1:0] cpu_data_lines, status_latched, wr_data;
    logic [DATA_W-1:0] last_vec = 8'h00;
    logic [IC_W-1:0] last_ic = 7'h00;
    logic cpu_ready, cpu_int, cpu_reset, miss, tick, samp, digit;
    logic wr_strobe, indirect_hit;
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;
    int n_wr = 0, n_ind = 0, n_miss = 0, n_int = 0, n_sel = 0;
    int n_tick = 0, n_samp = 0, n_dig = 0, n_wait = 0;
    int b_wr, b_ind, b_miss, b_int, b_sel, b_tick, b_samp, b_dig, b_wait;
    interbus_if bus ();
    always #2.5 clk = ~clk;
    interbus_controller interbus_controller_inst (.clk(clk), .reset(reset),
        .bus(bus.controller), .cpu_req(cpu_req), .cpu_wr(cpu_wr),
        .cpu_address_lines(addr), .cpu_data_out(wdat), .cpu_sync(cpu_sync),
        .cpu_status(cpu_status), .cpu_int_enable(int_en),
        .line_pulse(line_pulse), .cpu_data_lines(cpu_data_lines),
        .cpu_ready(cpu_ready), .cpu_int(cpu_int), .cpu_reset(cpu_reset),
        .status_latched(status_latched), .missing_ack_irq(miss),
        .line_tick_irq(tick), .sample_strobe(samp), .digit_strobe(digit));
    interbus_module #(.MY_ADDR(7'h10), .MY_VEC(3'h2)) interbus_module_inst (
        .clk(clk), .reset(reset), .bus(bus.module_end), .irq_req(irq_req),
        .rd_data(rd_data), .wr_data(wr_data), .wr_strobe(wr_strobe),
        .indirect_hit(indirect_hit));
    interbus_props interbus_props_inst (.clk(clk), .reset(reset),
        .sel_n(bus.sel_n), .wr_n(bus.wr_n), .ack_n(bus.ack_n),
        .ctl_data_oe_n(bus.ctl_data_oe_n), .mod_data_oe_n(bus.mod_data_oe_n),
        .module_data_lines(bus.module_data_lines), .irq_grant(bus.irq_grant),
        .module_irq_request_n(bus.module_irq_request_n),
        .realtime_lanes(bus.realtime_lanes));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (wr_strobe === 1'b1) n_wr <= n_wr + 1;
        if (indirect_hit === 1'b1) n_ind <= n_ind + 1;
        if (miss === 1'b1) n_miss <= n_miss + 1;
        if (cpu_int === 1'b1) n_int <= n_int + 1;
        if (cpu_int === 1'b1) last_vec <= cpu_data_lines;
        if (bus.sel_n === 1'b0) n_sel <= n_sel + 1;
        if (bus.sel_n === 1'b0) last_ic <= bus.module_addr_ctrl;
        if (tick === 1'b1) n_tick <= n_tick + 1;
        if (samp === 1'b1) n_samp <= n_samp + 1;
        if (digit === 1'b1) n_dig <= n_dig + 1;
        if (cpu_ready === 1'b0) n_wait <= n_wait + 1;
        // a hang ends the run here rather than never
        if (cyc == 20000)
        begin
            fails++;
            $display("mismatch at %0t: run timed out", $time);
            stop_test();
        end
    end
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp,
        input string what);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got,
                exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int exp, input string what);
        total_checks++;
        if (got != exp)
        begin
            fails++;
            $display("mismatch at %0t: %s got %0d exp %0d", $time, what, got,
                exp);
        end
    endtask
    task automatic snap();
        b_wr = n_wr;
        b_ind = n_ind;
        b_miss = n_miss;
        b_int = n_int;
        b_sel = n_sel;
        b_tick = n_tick;
        b_samp = n_samp;
        b_dig = n_dig;
        b_wait = n_wait;
    endtask
    // one memory cycle; waits out ack or the 400-cycle timeout
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d);
        int n;
        snap();
        @(posedge clk);
        cpu_req <= 1'b1;
        cpu_wr <= wr;
        addr <= a;
        wdat <= d;
        @(posedge clk);
        cpu_req <= 1'b0;
        repeat (3) @(negedge clk);
        n = 0;
        while (!(cpu_ready === 1'b1 && bus.ack_n === 1'b1) && n < 500)
        begin
            @(negedge clk);
            n++;
        end
        repeat (12) @(negedge clk);
    endtask
    task automatic line(input int gap);
        repeat (gap) @(posedge clk);
        line_pulse <= 1'b1;
        @(posedge clk);
        line_pulse <= 1'b0;
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        chk_val(8'(cpu_reset), 8'h01, "reset out");
        chk_val(8'(bus.module_addr_ctrl), 8'h7F, "idle lines");
        line(2);
        repeat (3) @(negedge clk);
        chk_val(8'(cpu_reset), 8'h00, "reset release");
        @(posedge clk);
        cpu_sync <= 1'b1;
        cpu_status <= 8'hA5;
        @(posedge clk);
        cpu_sync <= 1'b0;
        cpu_status <= 8'h3C;
        repeat (3) @(negedge clk);
        chk_val(status_latched, 8'hA5, "status");
        // indirect before any direct access is refused
        xfer(1'b1, 16'hEE00, 8'h11);
        chk_cnt(n_ind - b_ind, 0, "unarmed indirect");
        chk_cnt(n_miss - b_miss, 1, "missing ack");
        chk_val(last_vec, PRIO_ACK, "ack vector");
        xfer(1'b1, 16'hEF00, 8'h5A);
        chk_cnt(n_wr - b_wr, 1, "write taken");
        chk_val(wr_data, 8'h5A, "write data");
        chk_val(8'(last_ic), 8'h10, "module lines");
        chk_cnt(n_miss - b_miss, 0, "acked write");
        chk_cnt(n_wait - b_wait, 3, "wait states");
        rd_data <= 8'hC3;
        xfer(1'b0, 16'hEF00, 8'h00);
        chk_val(cpu_data_lines, 8'hC3, "read data");
        xfer(1'b1, 16'hEE00, 8'h96);
        chk_cnt(n_ind - b_ind, 1, "armed indirect");
        chk_cnt(n_miss - b_miss, 0, "indirect acked");
        xfer(1'b1, 16'hB500, 8'h22);
        chk_val(8'(last_ic), 8'h4A, "other module lines");
        chk_cnt(n_miss - b_miss, 1, "absent module");
        xfer(1'b0, 16'h6F00, 8'h00);
        chk_cnt(n_sel - b_sel, 0, "low half not module");
        snap();
        @(posedge clk);
        int_en <= 1'b0;
        irq_req <= 1'b1;
        @(posedge clk);
        irq_req <= 1'b0;
        repeat (20) @(negedge clk);
        chk_cnt(n_int - b_int, 0, "interrupt held off");
        @(posedge clk);
        int_en <= 1'b1;
        repeat (20) @(negedge clk);
        chk_cnt(n_int - b_int, 1, "module interrupt");
        chk_val(last_vec, 8'h04, "module vector");
        line(799);
        line(799);
        line(799);
        repeat (50) @(posedge clk);
        snap();
        line(749);
        repeat (49) @(posedge clk);
        chk_cnt(n_tick - b_tick, 8, "ticks per line");
        chk_cnt(n_dig - b_dig, 8, "digit pace");
        chk_cnt(n_samp - b_samp, 4, "sample pace");
        chk_val(last_vec, PRIO_TICK, "tick vector");
        stop_test();
    end
endmodule
`default_nettype wire
